//--- rtl/octal_dac_pkg.sv
// Constants, field layout and carrier types of the octal DAC serial front end
package octal_dac_pkg;

	// Frame geometry
	localparam int         WORD_BITS   = 16;
	localparam int         CHANNELS    = 8;
	localparam int         CODE_BITS   = 8;
	localparam logic [4:0] FRAME_EDGES = 5'h10;   // Falling edges in a full frame
	localparam logic [4:0] ABORT_EDGES = 5'h0f;   // Rise before this edge aborts
	localparam logic [4:0] COUNT_MAX   = 5'h1f;   // Edge counter saturation

	// Field positions inside the captured word
	localparam int CMD_MSB  = 15;
	localparam int CMD_LSB  = 12;
	localparam int DATA_MSB = 11;
	localparam int DATA_LSB = 4;

	// Command codes; 4'h0..4'h7 write the channel of that number
	localparam logic [3:0] CMD_MODE       = 4'h8;
	localparam logic [3:0] CMD_UPDATE_ALL = 4'h9;
	localparam logic [3:0] CMD_BROADCAST  = 4'ha;
	localparam logic [3:0] CMD_PD_LOW     = 4'hb;
	localparam logic [3:0] CMD_PD_HIGH    = 4'hc;
	localparam logic [3:0] CMD_PD_OPEN    = 4'hd;
	localparam logic [3:0] CMD_POWER_UP   = 4'he;

	// Reset values
	localparam logic [7:0] CODE_RESET = 8'h00;
	localparam logic       MODE_RESET = 1'b0;    // Write-through
	localparam logic [2:0] PIN_RESET  = 3'h6;    // Clock high, frame idle, data low

	// Output termination of one channel
	typedef enum logic [1:0] {
		TERM_ACTIVE = 2'b00,
		TERM_LOW    = 2'b01,
		TERM_HIGH   = 2'b10,
		TERM_OPEN   = 2'b11
	} term_e;

	// State of one analog channel as handed to the converter
	typedef struct packed {
		term_e      term;
		logic [7:0] code;
	} chan_s;

endpackage

//--- rtl/octal_dac_serial_input_frame.sv
// Serial frame capture, command decode and channel state of an octal 8-bit DAC
//
// Summary of operation
// - With frame select low, data is shifted into a 16-bit register on each falling clock.
// - Frame select rising after the 16th falling edge acts on the word and updates the DAC.
// - Frame select rising before the 16th falling edge aborts and leaves channels untouched.
// - The daisy output carries shifted-through data only beyond 16 clocks of one frame.
// - Chained devices sharing frame select all update on its single rising edge.
// - After reset every channel reads code zero until the first valid complete frame.
// - Each channel powers down on its own into one of three termination states.
// - The word selects mode, power-down state, channel register and output value.
`timescale 1ns/1ps
module octal_dac_serial_input_frame (
	input  wire logic                      mclk,
	input  wire logic                      rst_n,
	input  wire logic                      sclkPin,
	input  wire logic                      syncPin_n,
	input  wire logic                      dinPin,
	output octal_dac_pkg::chan_s [7:0]     chanOut,
	output logic                           dout,
	output logic                           written
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation and edge detection

	logic [2:0]  pinS;
	logic        sclkPrev;
	logic        syncPrev_n;
	logic [4:0]  bitCount;
	logic [15:0] shiftReg;
	logic [7:0]  chanReg [8];
	logic        holdMode;

	// Pins come from the host clock, so never read them raw
	pin_sync #(
		.WIDTH     (3),
		.RESET_VAL (octal_dac_pkg::PIN_RESET)
	) u_pin_sync (
		.clk     (mclk),
		.rst_n   (rst_n),
		.pinIn   ({sclkPin, syncPin_n, dinPin}),
		.pinSync (pinS)
	);

	wire sclkS       = pinS[2];
	wire syncS_n     = pinS[1];
	wire dinS        = pinS[0];
	wire sclkFall    = sclkPrev & ~sclkS;
	wire syncRise    = ~syncPrev_n & syncS_n;
	wire frameActive = ~syncS_n;
	// 15 edges is short too, so 16 is the single threshold
	// full frames only
	wire applyWord   = syncRise && (bitCount >= octal_dac_pkg::FRAME_EDGES);

	// Previous samples for edge detection
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sclkPrev   <= 1'b1;
			syncPrev_n <= 1'b1;
		end else begin
			sclkPrev   <= sclkS;
			syncPrev_n <= syncS_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Frame capture

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bitCount <= 5'h00;
		end else if (!frameActive) begin
			bitCount <= 5'h00;
		end else if (sclkFall && bitCount != octal_dac_pkg::COUNT_MAX) begin
			bitCount <= bitCount + 5'h01;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			shiftReg <= 16'h0000;
		end else if (frameActive && sclkFall) begin
			shiftReg <= {shiftReg[14:0], dinS};
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dout <= 1'b0;
		end else if (!frameActive) begin
			dout <= 1'b0;
		end else if (sclkFall) begin
			dout <= (bitCount >= octal_dac_pkg::FRAME_EDGES) ? shiftReg[15] : 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command decode

	wire [3:0] cmd     = shiftReg[octal_dac_pkg::CMD_MSB:octal_dac_pkg::CMD_LSB];
	wire [7:0] dataVal = shiftReg[octal_dac_pkg::DATA_MSB:octal_dac_pkg::DATA_LSB];
	wire       isPd    = (cmd == octal_dac_pkg::CMD_PD_LOW) ||
	                     (cmd == octal_dac_pkg::CMD_PD_HIGH) ||
	                     (cmd == octal_dac_pkg::CMD_PD_OPEN);
	// PD commands are consecutive, so the offset gives the termination
	wire [1:0] pdOffset = 2'(cmd - octal_dac_pkg::CMD_PD_LOW);
	wire octal_dac_pkg::term_e pdTerm = octal_dac_pkg::term_e'(2'(pdOffset + 2'b01));

	octal_dac_pkg::chan_s [7:0] next_chanOut;
	logic [7:0]                 next_chanReg [8];
	logic                       next_holdMode;

	always_comb begin
		next_chanOut  = chanOut;
		next_chanReg  = chanReg;
		next_holdMode = holdMode;
		if (applyWord) begin
			case (cmd)
				octal_dac_pkg::CMD_MODE: begin
					next_holdMode = dataVal[0];
				end
				octal_dac_pkg::CMD_UPDATE_ALL: begin
					for (int i = 0; i < octal_dac_pkg::CHANNELS; i++) begin
						next_chanOut[i].code = chanReg[i];
					end
				end
				octal_dac_pkg::CMD_BROADCAST: begin
					for (int i = 0; i < octal_dac_pkg::CHANNELS; i++) begin
						next_chanReg[i]      = dataVal;
						next_chanOut[i].code = dataVal;
					end
				end
				octal_dac_pkg::CMD_PD_LOW, octal_dac_pkg::CMD_PD_HIGH,
				octal_dac_pkg::CMD_PD_OPEN, octal_dac_pkg::CMD_POWER_UP: begin
					for (int i = 0; i < octal_dac_pkg::CHANNELS; i++) begin
						if (dataVal[i]) begin
							next_chanOut[i].term = isPd ? pdTerm
							                            : octal_dac_pkg::TERM_ACTIVE;
						end
					end
				end
				default: begin
					// Channel write; code 4'hf falls here and is ignored
					if (!cmd[3]) begin
						next_chanReg[cmd[2:0]] = dataVal;
						if (!holdMode) begin
							next_chanOut[cmd[2:0]].code = dataVal;
						end
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Channel state

	// zero code from reset; only a full frame changes it
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			chanOut  <= '0;
			holdMode <= octal_dac_pkg::MODE_RESET;
			written  <= 1'b0;
			for (int i = 0; i < octal_dac_pkg::CHANNELS; i++) begin
				chanReg[i] <= octal_dac_pkg::CODE_RESET;
			end
		end else begin
			chanOut  <= next_chanOut;
			holdMode <= next_holdMode;
			written  <= written | applyWord;
			chanReg  <= next_chanReg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_fullEnd;
		syncRise && (bitCount >= octal_dac_pkg::FRAME_EDGES);
	endsequence

	sequence s_shortEnd;
		syncRise && (bitCount < octal_dac_pkg::ABORT_EDGES);
	endsequence

	property p_shiftIn;
		(frameActive && sclkFall) |=> (shiftReg[0] == $past(dinS)) &&
		                              (shiftReg[15:1] == $past(shiftReg[14:0]));
	endproperty
	a_shiftIn: assert property (p_shiftIn) else $error("bit not shifted in");

	property p_fullUpdate;
		s_fullEnd ##0 (cmd == octal_dac_pkg::CMD_BROADCAST) |=>
			chanOut[0].code == $past(dataVal) && chanOut[7].code == $past(dataVal) && written;
	endproperty
	a_fullUpdate: assert property (p_fullUpdate) else $error("full frame not applied");

	property p_abort;
		s_shortEnd |=> (chanOut == $past(chanOut)) && (written == $past(written));
	endproperty
	a_abort: assert property (p_abort) else $error("aborted frame changed state");

	property p_daisy;
		(frameActive && sclkFall) |=>
			dout == (($past(bitCount) >= octal_dac_pkg::FRAME_EDGES) ? $past(shiftReg[15]) : 1'b0);
	endproperty
	a_daisy: assert property (p_daisy) else $error("daisy output wrong");

	property p_updateAll;
		s_fullEnd ##0 (cmd == octal_dac_pkg::CMD_UPDATE_ALL) |=>
			chanOut[0].code == $past(chanReg[0]) && chanOut[5].code == $past(chanReg[5]);
	endproperty
	a_updateAll: assert property (p_updateAll) else $error("simultaneous update missed");

	property p_resetZero;
		!written |-> (chanOut == '0);
	endproperty
	a_resetZero: assert property (p_resetZero) else $error("output nonzero before write");

	property p_powerDown;
		s_fullEnd ##0 (cmd == octal_dac_pkg::CMD_PD_OPEN) ##0 dataVal[2] |=>
			chanOut[2].term == octal_dac_pkg::TERM_OPEN;
	endproperty
	a_powerDown: assert property (p_powerDown) else $error("power down not taken");

	property p_chanWrite;
		s_fullEnd ##0 (cmd == 4'h3) ##0 !holdMode |=> chanOut[3].code == $past(dataVal);
	endproperty
	a_chanWrite: assert property (p_chanWrite) else $error("channel write wrong");

	property p_edge15;
		syncRise && (bitCount == octal_dac_pkg::ABORT_EDGES) |=> $stable(chanOut) [*2];
	endproperty
	a_edge15: assert property (p_edge15) else $error("15-edge frame applied");

endmodule

//--- rtl/pin_sync.sv
// Two-stage synchroniser for asynchronous input pins
`timescale 1ns/1ps
module pin_sync #(
	parameter int         WIDTH     = 3,
	parameter logic [2:0] RESET_VAL = 3'h0
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] pinSync
);

	logic [WIDTH-1:0] stage1;

	// First stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1  <= RESET_VAL[WIDTH-1:0];
			pinSync <= RESET_VAL[WIDTH-1:0];
		end else begin
			stage1  <= pinIn;
			pinSync <= stage1;
		end
	end

endmodule

//--- tb/octal_dac_serial_input_frame_tb_top.sv
// Self-checking bench of the octal DAC serial frame front end
`timescale 1ns/1ps
module octal_dac_serial_input_frame_tb_top;
	typedef struct packed {
		logic [15:0]          word;
		logic [2:0]           ch;
		octal_dac_pkg::chan_s exp;
	} row_s;

	logic                       mclk;
	logic                       rst_n;
	logic                       sclkPin;
	logic                       syncPin_n;
	logic                       dinPin;
	octal_dac_pkg::chan_s [7:0] chanOut;
	logic                       dout;
	logic                       written;
	logic                       go;
	logic                       done;
	logic [31:0]                word;
	logic [5:0]                 nBits;
	logic [31:0]                shiftOut;
	int                         num_errors;
	int                         n_checks;
	row_s                       rows [6];

	////////////////////////////////////////////////////////////////////////////////
	octal_dac_serial_input_frame octal_dac_serial_input_frame_inst (
		.mclk(mclk), .rst_n(rst_n), .sclkPin(sclkPin), .syncPin_n(syncPin_n),
		.dinPin(dinPin), .chanOut(chanOut), .dout(dout), .written(written));
	serial_host serial_host_inst (
		.mclk(mclk), .go(go), .word(word), .nBits(nBits), .sclkPin(sclkPin),
		.syncPin_n(syncPin_n), .dinPin(dinPin), .done(done));

	// Daisy output taken at sclk rise, well after it settles
	always @(posedge sclkPin)
		shiftOut <= {shiftOut[30:0], dout};

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [79:0] seen, input logic [79:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Go is held until done so the host cannot miss it
	task automatic send(input logic [31:0] w, input logic [5:0] n);
		int k;
		@(negedge mclk);
		word = w;
		nBits = n;
		go = 1'b1;
		for (k = 0; k < 400 && done !== 1'b1; k++)
			@(posedge mclk);
		@(negedge mclk);
		go = 1'b0;
		if (k == 400) begin
			num_errors++;
			print_verdict();
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	initial begin
		int r;
		rst_n = 1'b0;
		go = 1'b0;
		word = '0;
		nBits = 6'h10;
		shiftOut = '0;
		num_errors = 0;
		n_checks = 0;
		rows = '{'{16'h0a50, 3'h0, 10'h0a5}, '{16'h7ff0, 3'h7, 10'h0ff},
			'{16'hb010, 3'h0, 10'h1a5}, '{16'hc800, 3'h7, 10'h2ff},
			'{16'hd060, 3'h1, 10'h300}, '{16'he870, 3'h7, 10'h0ff}};
		repeat (6) @(negedge mclk);
		rst_n = 1'b1;
		repeat (4) @(negedge mclk);
		check("written", written, 1'b0);
		check("chan reset", chanOut, '0);
		for (r = 0; r < 6; r++) begin
			send(rows[r].word, 6'h10);
			check("row chan", chanOut[rows[r].ch], rows[r].exp);
		end
		check("written", written, 1'b1);
		$display("test rows done");
		// Short frames and the unused command leave channel 0 alone
		for (r = 14; r < 17; r++) begin
			send(r == 16 ? 32'hf110 : 32'h0110, r[5:0]);
			check("refused frame", chanOut[0], 10'h0a5);
		end
		$display("test refused done");
		send(32'ha3c0, 6'h10);
		check("broadcast", chanOut[5], 10'h03c);
		send(32'h8010, 6'h10);
		send(32'h2550, 6'h10);
		check("hold mode", chanOut[2], 10'h03c);
		send(32'h9000, 6'h10);
		check("update all", chanOut[2], 10'h055);
		send(32'h8000, 6'h10);
		$display("test modes done");
		shiftOut = '0;
		send({16'h5aa0, 16'h3770}, 6'h20);
		check("daisy out", shiftOut, 32'h00005aa0);
		check("chained word", chanOut[3], 10'h077);
		$display("test daisy done");
		rst_n = 1'b0;
		@(negedge mclk);
		check("reset chan", chanOut, '0);
		check("reset written", written, 1'b0);
		rst_n = 1'b1;
		$display("test reset done");
		print_verdict();
	end
endmodule

//--- tb/serial_host.sv
// Host controller model driving the three-wire serial frame pins
`timescale 1ns/1ps
module serial_host (
	input  wire logic        mclk,
	input  wire logic        go,
	input  wire logic [31:0] word,
	input  wire logic [5:0]  nBits,
	output logic             sclkPin,
	output logic             syncPin_n,
	output logic             dinPin,
	output logic             done
);
	int i;

	////////////////////////////////////////////////////////////////////////////////
	// Idle clock and frame select high, data low, then one frame per go; sclk stands still between frames
	initial begin
		sclkPin = 1'b1;
		syncPin_n = 1'b1;
		dinPin = 1'b0;
		done = 1'b0;
		forever begin
			@(negedge mclk iff go);
			syncPin_n <= 1'b0;
			// MSB first, held around the fall
			for (i = nBits - 1; i >= 0; i--) begin
				dinPin <= word[i];
				repeat (4) @(negedge mclk);
				sclkPin <= 1'b0;
				repeat (4) @(negedge mclk);
				sclkPin <= 1'b1;
			end
			repeat (4) @(negedge mclk);
			syncPin_n <= 1'b1;
			dinPin <= ~dinPin;   // Released line shows no stale bit
			repeat (6) @(negedge mclk);
			done <= 1'b1;
			@(negedge mclk);
			done <= 1'b0;
		end
	end
endmodule
